// >>> udt_pins_model.sv
// udt_pins_model: far side of the timer, driving the count pin and the direction pin.
// assumes the bench asks for each falling edge with a one-cycle pulse on fall_req.
`timescale 1ns/1ns
`default_nettype none
module udt_pins_model
  import udt_pkg::*;
(
  // clock
  input  wire logic clk,
  // bench requests
  input  wire logic fall_req,
  input  wire logic dir_up,
  // pins
  output logic      external_count_pin,
  output logic      direction_pin
);
  // count pin idles high, so each request gives exactly one falling edge
  initial begin
    external_count_pin = 1'h1;
    direction_pin      = 1'h0;
  end
  always @(posedge clk) begin
    external_count_pin <= !fall_req;
    direction_pin      <= dir_up;
  end
endmodule : udt_pins_model
`default_nettype wire

// >>> udt_tick.sv
// udt_pkg: constants, control carrier and mode codes for the up/down reload timer.
// udt_tick: count-input selector (divide-by-12 prescaler or falling edge of count pin).
// assumes every input is synchronous to clk; rst_n is synchronous, active low.
package udt_pkg;
  localparam int unsigned   PRESCALE_DIV   = 12;
  localparam logic [3:0]    PRESCALE_LAST  = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0]    PRESCALE_RST   = 4'h0;
  localparam logic [15:0]   COUNT_TOP      = 16'hFFFF;
  localparam logic [15:0]   COUNT_RST      = 16'h0000;
  localparam logic [15:0]   RELOAD_RST     = 16'h0000;
  localparam logic [15:0]   COUNT_STEP     = 16'h0001;
  localparam int unsigned   HIGH_LSB       = 8;

  typedef struct packed {
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic down_count_enable;
  } udt_ctrl_t;

  typedef enum logic [2:0] {
    MODE_CAPTURE = 3'b001,
    MODE_RELOAD  = 3'b010,
    MODE_BAUD    = 3'b100
  } udt_mode_t;
endpackage : udt_pkg

`timescale 1ns/1ns
`default_nettype none

module udt_tick
  import udt_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // selection
  input  wire logic counter_timer_select,
  input  wire logic external_count_pin,
  // selected count event, one cycle
  output logic      sel_tick
);
  logic [3:0] presc_ff;
  logic [3:0] nxt_presc;
  logic       pin_prev_ff;
  wire        presc_wrap = (presc_ff == PRESCALE_LAST);
  wire        pin_fall   = pin_prev_ff & ~external_count_pin;

  // prescaler runs freely so the timer phase does not depend on run control
  assign nxt_presc = presc_wrap ? PRESCALE_RST : presc_ff + 4'h1;
  assign sel_tick  = counter_timer_select ? pin_fall : presc_wrap;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_ff    <= PRESCALE_RST;
      pin_prev_ff <= 1'b1;
    end else begin
      presc_ff    <= nxt_presc;
      pin_prev_ff <= external_count_pin;
    end
  end
endmodule : udt_tick

`default_nettype wire

// >>> udt_timer.sv
// udt_timer: 16-bit up/down auto-reload timer/counter built from two cascaded bytes.
// assumes control bits, pins and software strobes are synchronous to clk (125 MHz).
// What this block does
// - count is a low byte and high byte, low cascading into high
// - select bit picks clock divided by 12 or external count pin
// - count advances only while run control is set
// - capture, auto-reload or baud mode chosen by three select bits
// - reload mode without down enable counts up only, reloading on overflow
// - in reload mode with down enable, direction pin high counts up, low counts down
// - up count at FFFFh overflows, sets overflow flag, requests interrupt, except in baud mode
// - up overflow loads the reload bytes into the count, except capture mode, which wraps to 0000h
// - down count underflows when count equals the reload value
// - underflow sets overflow flag and loads FFFFh into the count
// - up/down mode toggles external flag on each wrap, no interrupt
`timescale 1ns/1ns
`default_nettype none

module udt_timer
  import udt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control bits
  input  wire udt_ctrl_t   ctrl,
  // pins
  input  wire logic        external_count_pin,
  input  wire logic        direction_pin,
  // software writes
  input  wire logic        count_wr,
  input  wire logic [15:0] count_wr_data,
  input  wire logic        reload_wr,
  input  wire logic [15:0] reload_wr_data,
  input  wire logic        overflow_flag_clr,
  input  wire logic        external_flag_clr,
  // state
  output logic [7:0]       count_low_byte,
  output logic [7:0]       count_high_byte,
  output logic [7:0]       reload_low_byte,
  output logic [7:0]       reload_high_byte,
  output logic             overflow_flag,
  output logic             external_flag,
  output logic             irq_req
);
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] reload_ff;
  logic        ovf_ff;
  logic        nxt_ovf;
  logic        ext_ff;
  logic        nxt_ext;
  logic        sel_tick;
  udt_mode_t   mode;

  udt_tick u_tick (
    .clk                  (clk),
    .rst_n                (rst_n),
    .counter_timer_select (ctrl.counter_timer_select),
    .external_count_pin   (external_count_pin),
    .sel_tick             (sel_tick)
  );

  // mode decode: baud select bits take precedence over capture/reload
  wire baud_sel = ctrl.receive_clock_select | ctrl.transmit_clock_select;
  assign mode = baud_sel ? MODE_BAUD
              : (ctrl.capture_reload_select ? MODE_CAPTURE : MODE_RELOAD);

  // a software count write refuses the step, so it cannot set a flag either
  wire step      = ctrl.run_control & sel_tick & ~count_wr;
  wire updown    = (mode == MODE_RELOAD) & ctrl.down_count_enable;
  wire count_dn  = updown & ~direction_pin;
  wire at_top    = (count_ff == COUNT_TOP);
  wire at_reload = (count_ff == reload_ff);
  wire wrap_up   = step & ~count_dn & at_top;
  wire wrap_dn   = step & count_dn & at_reload;
  wire wrap      = wrap_up | wrap_dn;
  // a baud-rate generator wrap reloads silently, without the flag
  wire flag_evt  = wrap & (mode != MODE_BAUD);

  wire [15:0] cnt_inc = count_ff + COUNT_STEP;
  wire [15:0] cnt_dec = count_ff - COUNT_STEP;

  always_comb begin
    nxt_count = count_ff;
    if (count_wr) begin
      nxt_count = count_wr_data;
    end else if (step) begin
      unique case (mode)
        MODE_CAPTURE: nxt_count = cnt_inc;
        MODE_RELOAD: begin
          if (count_dn) begin
            nxt_count = at_reload ? COUNT_TOP : cnt_dec;
          end else begin
            nxt_count = at_top ? reload_ff : cnt_inc;
          end
        end
        MODE_BAUD: nxt_count = at_top ? reload_ff : cnt_inc;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  assign nxt_ovf = flag_evt | (ovf_ff & ~overflow_flag_clr);
  // toggle wins over clear; only the up/down mode toggles it
  assign nxt_ext = (updown & wrap) ? ~ext_ff
                 : (ext_ff & ~external_flag_clr);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff  <= COUNT_RST;
      reload_ff <= RELOAD_RST;
      ovf_ff    <= 1'b0;
      ext_ff    <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      reload_ff <= reload_wr ? reload_wr_data : reload_ff;
      ovf_ff    <= nxt_ovf;
      ext_ff    <= nxt_ext;
    end
  end

  assign count_low_byte   = count_ff[HIGH_LSB-1:0];
  assign count_high_byte  = count_ff[15:HIGH_LSB];
  assign reload_low_byte  = reload_ff[HIGH_LSB-1:0];
  assign reload_high_byte = reload_ff[15:HIGH_LSB];
  assign overflow_flag    = ovf_ff;
  assign external_flag    = ext_ff;
  // external flag never feeds the request
  assign irq_req          = ovf_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_up_wrap_reload: assert property (
    wrap_up && !count_wr && mode != MODE_CAPTURE |=> count_ff == $past(reload_ff))
    else $error("up overflow did not load reload value");
  a_down_wrap_top: assert property (
    wrap_dn && !count_wr |=> count_ff == 16'hFFFF && ovf_ff)
    else $error("underflow did not load FFFFh and set flag");
  a_down_step: assert property (
    step && count_dn && !at_reload && !count_wr |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("down count step wrong");
  a_ovf_sticky: assert property (
    ovf_ff && !overflow_flag_clr |=> ovf_ff)
    else $error("overflow flag dropped without clear");
  a_up_wrap_irq: assert property (
    wrap_up && mode != MODE_BAUD |=> ovf_ff && irq_req)
    else $error("overflow did not raise request");
  a_ext_toggle: assert property (
    updown && wrap |=> ext_ff != $past(ext_ff) && irq_req == ovf_ff)
    else $error("external flag did not toggle");
  a_stop_hold: assert property (
    !ctrl.run_control && !count_wr |=> $stable(count_ff))
    else $error("count moved while stopped");
  a_div_twelve: assert property (
    sel_tick && !ctrl.counter_timer_select |=> !sel_tick [*8] ##3 !sel_tick ##1 sel_tick
      or ctrl.counter_timer_select)
    else $error("timer input not divided by 12");
  a_pin_fall: assert property (
    ctrl.counter_timer_select && $fell(external_count_pin) |-> sel_tick)
    else $error("falling pin edge not counted");
  a_byte_cascade: assert property (
    step && !count_dn && count_ff[7:0] == 8'hFF && !at_top && !count_wr
      |=> count_high_byte == $past(count_high_byte) + 8'h01 && count_low_byte == 8'h00)
    else $error("low byte did not carry into high byte");

  // helper for the divide check: cycles since the last timer tick
  logic [3:0] tick_gap_ff;
  logic       tick_seen_ff;
  wire        timer_tick    = sel_tick & ~ctrl.counter_timer_select;
  wire        gap_restart   = timer_tick | ctrl.counter_timer_select;
  wire  [3:0] nxt_tick_gap  = gap_restart ? PRESCALE_RST : tick_gap_ff + 4'h1;
  wire        nxt_tick_seen = timer_tick | (tick_seen_ff & ~ctrl.counter_timer_select);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_gap_ff  <= PRESCALE_RST;
      tick_seen_ff <= 1'b0;
    end else begin
      tick_gap_ff  <= nxt_tick_gap;
      tick_seen_ff <= nxt_tick_seen;
    end
  end

  // the first tick after a switch to timer operation only arms the check
  a_tick_spacing: assert property (
    !ctrl.counter_timer_select && tick_seen_ff
      |-> sel_tick == (tick_gap_ff == PRESCALE_LAST))
    else $error("timer ticks not twelve cycles apart");

  // reset and software writes
  a_reset_state: assert property (
    disable iff (1'b0)
    !rst_n
      |=> count_ff == COUNT_RST && reload_ff == RELOAD_RST && !ovf_ff && !ext_ff)
    else $error("state not cleared by reset");

  a_count_write: assert property (
    count_wr
      |=> count_ff == $past(count_wr_data))
    else $error("count write did not land");

  a_write_no_flag: assert property (
    count_wr && !ovf_ff
      |=> !ovf_ff)
    else $error("refused step still set the flag");

  a_reload_write: assert property (
    reload_wr
      |=> reload_ff == $past(reload_wr_data))
    else $error("reload write did not land");

  a_reload_hold: assert property (
    !reload_wr
      |=> $stable(reload_ff))
    else $error("reload value moved without a write");

  // counting steps
  a_up_step: assert property (
    step && !at_top && (mode != MODE_RELOAD || !ctrl.down_count_enable || direction_pin)
      |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("up count step wrong");

  a_cascade_hold: assert property (
    step && !count_dn && count_ff[7:0] != 8'hFF
      |=> count_high_byte == $past(count_high_byte))
    else $error("high byte moved without a carry");

  a_down_dir: assert property (
    step && !at_reload && mode == MODE_RELOAD && ctrl.down_count_enable && !direction_pin
      |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("low direction pin did not count down");

  a_down_wrap_dir: assert property (
    wrap_dn
      |-> mode == MODE_RELOAD && ctrl.down_count_enable && !direction_pin)
    else $error("underflow outside down counting");

  a_idle_hold: assert property (
    !step && !count_wr
      |=> $stable(count_ff))
    else $error("count moved without a step");

  a_capture_wrap: assert property (
    wrap_up && mode == MODE_CAPTURE
      |=> count_ff == 16'h0000 && ovf_ff)
    else $error("capture wrap did not reach zero with flag");

  // baud wraps reload silently; the wrap leaves the flag alone, only a clear can drop it
  a_baud_silent: assert property (
    wrap && mode == MODE_BAUD
      |=> count_ff == $past(reload_ff) && ovf_ff == ($past(ovf_ff) && !$past(overflow_flag_clr)))
    else $error("baud wrap wrong or touched the flag");

  // the first sample after reset has no valid pin history, so it is skipped
  a_pin_no_fall: assert property (
    $past(rst_n) && ctrl.counter_timer_select && !$fell(external_count_pin)
      |-> !sel_tick)
    else $error("count event without a falling pin edge");

  // flag behaviour
  a_ovf_clear: assert property (
    overflow_flag_clr && !flag_evt
      |=> !ovf_ff)
    else $error("overflow flag clear ignored");

  // a set and a clear in one cycle leave the flag set
  a_ovf_set_wins: assert property (
    flag_evt && overflow_flag_clr
      |=> ovf_ff && irq_req)
    else $error("clear beat a same-cycle overflow");

  a_ovf_cause: assert property (
    !ovf_ff && !flag_evt
      |=> !ovf_ff && !irq_req)
    else $error("overflow flag set with no wrap");

  a_run_flag: assert property (
    !ctrl.run_control && !ovf_ff
      |=> !ovf_ff)
    else $error("overflow flag set while stopped");

  // the toggle is the only hardware write to the external flag
  a_ext_hold: assert property (
    !(updown && wrap) && !external_flag_clr
      |=> $stable(ext_ff))
    else $error("external flag moved with no up/down wrap");

  a_ext_clear: assert property (
    external_flag_clr && !(updown && wrap)
      |=> !ext_ff)
    else $error("external flag clear ignored");

  a_ext_fixed_up: assert property (
    wrap && !ctrl.down_count_enable && !external_flag_clr
      |=> $stable(ext_ff))
    else $error("external flag toggled outside up/down mode");

  c_up_wrap:   cover property (wrap_up && mode == MODE_RELOAD);
  c_down_wrap: cover property (wrap_dn);
  c_baud_wrap: cover property (wrap && mode == MODE_BAUD);
  c_set_clear: cover property (flag_evt && overflow_flag_clr);
  c_timer_tick: cover property (timer_tick && ctrl.run_control);
endmodule : udt_timer

`default_nettype wire

// >>> udt_timer_test.sv
// udt_timer_test: directed bench for the up/down reload timer.
// assumes udt_pkg, udt_tick, udt_timer and udt_pins_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module udt_timer_test
  import udt_pkg::*;
;
  logic        clk, rst_n, count_wr, reload_wr, overflow_flag_clr, external_flag_clr;
  udt_ctrl_t   ctrl;
  logic [15:0] count_wr_data, reload_wr_data;
  logic [7:0]  count_low_byte, count_high_byte, reload_low_byte, reload_high_byte;
  logic        overflow_flag, external_flag, irq_req, cpin, dpin, fall_req, dir_up;
  logic [34:0] st;
  int          errors, checks;
  logic [5:0]  mode_c [3] = '{6'h38, 6'h34, 6'h32};
  logic [15:0] mode_q [3] = '{16'h0000, 16'h1234, 16'h1234};
  logic [2:0]  mode_f [3] = '{3'h5, 3'h0, 3'h0};
  // reload, count, then the three flags, compared as one word
  assign st = {reload_high_byte, reload_low_byte, count_high_byte, count_low_byte,
               overflow_flag, external_flag, irq_req};
  udt_pins_model u_pins (.clk(clk), .fall_req(fall_req), .dir_up(dir_up),
    .external_count_pin(cpin), .direction_pin(dpin));
  udt_timer u_dut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .external_count_pin(cpin),
    .direction_pin(dpin), .count_wr(count_wr), .count_wr_data(count_wr_data),
    .reload_wr(reload_wr), .reload_wr_data(reload_wr_data),
    .overflow_flag_clr(overflow_flag_clr), .external_flag_clr(external_flag_clr),
    .count_low_byte(count_low_byte), .count_high_byte(count_high_byte),
    .reload_low_byte(reload_low_byte), .reload_high_byte(reload_high_byte),
    .overflow_flag(overflow_flag), .external_flag(external_flag), .irq_req(irq_req));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // sampled one step after the edge so the design's updates have landed
  task automatic chk(input logic [34:0] exp, input string what);
    #1;
    checks++;
    if (st !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, st, exp);
    end
    $display("test %s done", what);
  endtask : chk
  task automatic setup(input logic [15:0] cnt, input logic [15:0] rel, input logic [5:0] c);
    @(posedge clk);
    count_wr          <= 1'h1;
    count_wr_data     <= cnt;
    reload_wr         <= 1'h1;
    reload_wr_data    <= rel;
    overflow_flag_clr <= 1'h1;
    external_flag_clr <= 1'h1;
    ctrl              <= c;
    @(posedge clk);
    count_wr          <= 1'h0;
    reload_wr         <= 1'h0;
    overflow_flag_clr <= 1'h0;
    external_flag_clr <= 1'h0;
  endtask : setup
  // one falling edge per round; the edge is counted two edges after the request
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      fall_req <= 1'h1;
      @(posedge clk);
      fall_req <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask : pulse
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'h0;
    ctrl = '0;
    {count_wr, reload_wr, overflow_flag_clr, external_flag_clr, fall_req, dir_up} = '0;
    count_wr_data = 16'h0000;
    reload_wr_data = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    chk(35'h0, "reset");
    setup(16'h00FF, 16'h1234, 6'h30);
    pulse(1);
    chk({16'h1234, 16'h0100, 3'h0}, "cascade");
    setup(16'hFFFE, 16'h1234, 6'h30);
    pulse(2);
    chk({16'h1234, 16'h1234, 3'h5}, "up reload");
    @(posedge clk);
    ctrl <= 6'h10;
    pulse(2);
    chk({16'h1234, 16'h1234, 3'h5}, "halted");
    setup(16'h1235, 16'h1234, 6'h31);
    pulse(1);
    chk({16'h1234, 16'h1234, 3'h0}, "down step");
    pulse(1);
    chk({16'h1234, 16'hFFFF, 3'h7}, "underflow");
    @(posedge clk);
    dir_up <= 1'h1;
    pulse(1);
    chk({16'h1234, 16'h1234, 3'h5}, "up wrap");
    for (int i = 0; i < 3; i++) begin
      setup(16'hFFFF, 16'h1234, mode_c[i]);
      pulse(1);
      chk({16'h1234, mode_q[i], mode_f[i]}, "mode");
    end
    setup(16'hFFFF, 16'h1234, 6'h31);
    @(posedge clk);
    fall_req          <= 1'h1;
    @(posedge clk);
    fall_req          <= 1'h0;
    overflow_flag_clr <= 1'h1;
    external_flag_clr <= 1'h1;
    @(posedge clk);
    overflow_flag_clr <= 1'h0;
    external_flag_clr <= 1'h0;
    @(posedge clk);
    chk({16'h1234, 16'h1234, 3'h7}, "set wins");
    setup(16'h0000, 16'h1234, 6'h20);
    repeat (120) @(posedge clk);
    chk({16'h1234, 16'h000A, 3'h0}, "prescale");
    tally_and_finish();
  end
endmodule : udt_timer_test
`default_nettype wire
